// [hdl/bprs_top.sv]
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`include "bprs_cfg.svh"
module bprs_top
  import bprs_pkg::*;
#(
  parameter int IDX_W = `BPRS_BTB_IDX_W
)
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    icache_inval,
  input  wire logic                    rs_flush_op,
  input  wire logic [`BPRS_ADDR_W-1:0] fetch_addr,
  input  wire logic                    fetch_valid,
  input  wire logic                    id_valid,
  input  wire bprs_kind_t              id_kind,
  input  wire logic                    id_foldable,
  input  wire bprs_ret_t               id_ret,
  input  wire logic                    id_ret_always,
  input  wire logic                    ex_valid,
  input  wire bprs_kind_t              ex_kind,
  input  wire logic                    ex_taken,
  input  wire logic                    ex_pred_taken,
  input  wire logic                    ex_ret_cond_true,
  input  wire bprs_ret_t               ex_ret,
  input  wire logic [`BPRS_ADDR_W-1:0] ex_pc,
  input  wire logic [`BPRS_ADDR_W-1:0] ex_target,
  input  wire logic [`BPRS_ADDR_W-1:0] ex_fallthru,
  input  wire logic                    ex_ext,
  input  wire logic [`BPRS_ADDR_W-1:0] is_pc,
  output logic                         pred_valid_r,
  output logic                         pred_taken_r,
  output logic [`BPRS_ADDR_W-1:0]      pred_target_r,
  output logic                         fold_r,
  output logic                         redirect_r,
  output logic [`BPRS_ADDR_W-1:0]      redirect_addr_r,
  output logic                         flush_r,
  output logic                         ret_pred_taken_r,
  output logic                         ret_stall_r
);
  typedef struct packed {
    logic [`BPRS_CR_W-1:0]   ctrl;
    bprs_bus_st_t            bus;
    logic [31:0]             rdata;
    logic                    pv;
    logic                    pt;
    logic [`BPRS_ADDR_W-1:0] ptgt;
    logic                    fold;
    logic                    redir;
    logic [`BPRS_ADDR_W-1:0] raddr;
    logic                    flush;
    logic                    rpt;
    logic                    rstall;
  } bprs_top_st_t;
  bprs_top_st_t r, nxt;
  logic rst_n;
  logic rst_q1_r;
  logic rst_q2_r;
  assign rst_n = rst_q2_r;

  // reset release synchroniser
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end
    else
    begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  logic                    pred_en, rs_en, bus_req, wr_ctrl, wr_address_space_identifier;
  logic                    inval;
  logic                    btb_hit, btb_taken, btb_ext, upd_hit;
  logic [`BPRS_ADDR_W-1:0] btb_tgt;
  logic                    upd_valid, upd_alloc, predictable;
  logic                    is_call, rs_push, rs_pop, rs_empty;
  logic                    id_ret_taken, ex_ret_pop, mispredict;
  logic [`BPRS_ADDR_W-1:0] rs_top;
  logic [`BPRS_RS_CNT_W-1:0] rs_cnt;

  assign pred_en = r.ctrl[`BPRS_CR_PRED_EN];
  assign rs_en   = r.ctrl[`BPRS_CR_RS_EN];
  assign bus_req = avs_read || avs_write;
  assign wr_ctrl = r.bus == BPRS_S_ACK && avs_write
                   && avs_address == `BPRS_REG_CTRL;
  assign wr_address_space_identifier = r.bus == BPRS_S_ACK && avs_write
                   && avs_address == `BPRS_REG_ADDRESS_SPACE_IDENTIFIER;
  assign inval = icache_inval || wr_address_space_identifier
                 || (wr_ctrl && avs_writedata[`BPRS_CR_INVAL]);

  // only direct branch and call forms are buffered
  always_comb
  begin
    case (ex_kind)
      BPRS_K_COND_K8, BPRS_K_COND_K21, BPRS_K_JMP_K10, BPRS_K_JMP_K21,
      BPRS_K_CALL_K10, BPRS_K_CALL_K21, BPRS_K_ALT_COND, BPRS_K_ALT_CMP:
        predictable = 1'b1;
      default:
        predictable = 1'b0;
    endcase
  end
  always_comb
  begin
    case (ex_kind)
      BPRS_K_CALL_K10, BPRS_K_CALL_K21, BPRS_K_ICALL, BPRS_K_MCALL,
      BPRS_K_TCALL:
        is_call = 1'b1;
      default:
        is_call = 1'b0;
    endcase
  end

  assign upd_valid = ce && ex_valid && predictable && pred_en;
  assign upd_alloc = ex_taken;
  assign mispredict = ex_valid && predictable && ex_taken != ex_pred_taken;
  assign rs_push = ex_valid && is_call;
  assign id_ret_taken = id_valid && rs_en && (id_ret == BPRS_R_MOV_LR
                        || id_ret == BPRS_R_POPM_PC
                        || id_ret == BPRS_R_LDM_PC
                        || (id_ret == BPRS_R_RET && id_ret_always));
  assign ex_ret_pop = ex_valid && ex_ret == BPRS_R_RET
                      && ex_ret_cond_true && rs_en;
  assign rs_pop = (id_ret_taken && !rs_empty) || ex_ret_pop;

  bprs_btb #(
    .IDX_W       (IDX_W)
  ) u_btb (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .inval       (inval),
    .look_addr   (fetch_addr),
    .look_hit    (btb_hit),
    .look_taken  (btb_taken),
    .look_target (btb_tgt),
    .look_ext    (btb_ext),
    .upd_valid   (upd_valid),
    .upd_alloc   (upd_alloc),
    .upd_taken   (ex_taken),
    .upd_addr    (ex_pc),
    .upd_target  (ex_target),
    .upd_ext     (ex_ext),
    .upd_hit     (upd_hit)
  );

  bprs_rstack u_rs (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .enable      (rs_en),
    .flush       (rs_flush_op),
    .push        (rs_push),
    .push_addr   (is_pc),
    .pop         (rs_pop),
    .empty       (rs_empty),
    .top         (rs_top),
    .count       (rs_cnt)
  );

  always_comb
  begin
    nxt        = r;
    nxt.pv     = 1'b0;
    nxt.fold   = 1'b0;
    nxt.redir  = 1'b0;
    nxt.flush  = 1'b0;
    nxt.rpt    = 1'b0;
    nxt.rstall = 1'b0;
    // fetch-side prediction
    if (fetch_valid && pred_en && btb_hit)
    begin
      nxt.pv   = 1'b1;
      nxt.pt   = btb_taken;
      nxt.ptgt = btb_tgt;
    end
    // fold only into branches/jumps, never calls or predictable partners
    if (id_valid && pred_en && id_foldable
        && (id_kind == BPRS_K_COND_K8 || id_kind == BPRS_K_COND_K21
        || id_kind == BPRS_K_JMP_K10 || id_kind == BPRS_K_JMP_K21))
      nxt.fold = 1'b1;
    // return from stack in decode
    if (id_ret_taken)
    begin
      nxt.rpt = 1'b1;
      if (rs_empty)
        nxt.rstall = 1'b1;
      else
      begin
        nxt.redir = 1'b1;
        nxt.raddr = rs_top;
        nxt.flush = 1'b1;
      end
    end
    // execute-time correction has priority over decode redirect
    if (mispredict)
    begin
      nxt.redir = 1'b1;
      nxt.flush = 1'b1;
      nxt.raddr = ex_taken ? ex_target : ex_fallthru;
    end
    else if (ex_ret_pop && !rs_empty)
    begin
      nxt.redir = 1'b1;
      nxt.raddr = rs_top;
      nxt.flush = 1'b1;
    end
    // avalon slave: one wait cycle, answer on the next
    case (r.bus)
      BPRS_S_IDLE:
        if (bus_req)
          nxt.bus = BPRS_S_ACK;
      BPRS_S_ACK:
      begin
        nxt.bus = BPRS_S_HOLD;
        if (avs_write && avs_address == `BPRS_REG_CTRL)
        begin
          nxt.ctrl[`BPRS_CR_PRED_EN] = avs_writedata[`BPRS_CR_PRED_EN];
          nxt.ctrl[`BPRS_CR_RS_EN]   = avs_writedata[`BPRS_CR_RS_EN];
        end
      end
      BPRS_S_HOLD:
        nxt.bus = BPRS_S_IDLE;
      default:
        nxt.bus = BPRS_S_IDLE;
    endcase
    nxt.rdata = 32'h0;
    if (r.bus == BPRS_S_IDLE && avs_read)
      case (avs_address)
        `BPRS_REG_CTRL:
          nxt.rdata = {29'h0, r.ctrl[`BPRS_CR_RS_EN], 1'b0,
                       r.ctrl[`BPRS_CR_PRED_EN]};
        `BPRS_REG_STATUS:
          nxt.rdata = {28'h0, rs_empty, rs_cnt};
        default:
          nxt.rdata = 32'h0;
      endcase
    else if (r.bus == BPRS_S_ACK)
      nxt.rdata = r.rdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r.ctrl   <= `BPRS_CR_RESET;
      r.bus    <= BPRS_S_IDLE;
      r.rdata  <= 32'h0;
      r.pv     <= 1'b0;
      r.pt     <= 1'b0;
      r.ptgt   <= '0;
      r.fold   <= 1'b0;
      r.redir  <= 1'b0;
      r.raddr  <= '0;
      r.flush  <= 1'b0;
      r.rpt    <= 1'b0;
      r.rstall <= 1'b0;
    end
    else if (ce)
    begin
      r.ctrl   <= nxt.ctrl;
      r.bus    <= nxt.bus;
      r.rdata  <= nxt.rdata;
      r.pv     <= nxt.pv;
      r.pt     <= nxt.pt;
      r.ptgt   <= nxt.ptgt;
      r.fold   <= nxt.fold;
      r.redir  <= nxt.redir;
      r.raddr  <= nxt.raddr;
      r.flush  <= nxt.flush;
      r.rpt    <= nxt.rpt;
      r.rstall <= nxt.rstall;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if (ce)
      avs_waitrequest <= !(r.bus == BPRS_S_IDLE && bus_req);
  end

  assign avs_readdata     = r.rdata;
  assign pred_valid_r     = r.pv;
  assign pred_taken_r     = r.pt;
  assign pred_target_r    = r.ptgt;
  assign fold_r           = r.fold;
  assign redirect_r       = r.redir;
  assign redirect_addr_r  = r.raddr;
  assign flush_r          = r.flush;
  assign ret_pred_taken_r = r.rpt;
  assign ret_stall_r      = r.rstall;
endmodule

// [pkg/bprs_cfg.svh]
`ifndef BPRS_CFG_SVH
`define BPRS_CFG_SVH
// How it works
// - fetch follows predicted path; a wrong guess flushes and redirects fetch.
// - folded branch passes its condition on; wrong guess flushes the partner.
// - prediction works only while the prediction enable bit is set.
// - only conditional branch, relative jump and call forms enter the buffer.
// - calls never fold; predictable forms never fold into a branch.
// - direct mapped, indexed by fetch address bits [IDX_W+1:2], bits above are tag.
// - entry holds tag, valid, target, two-bit history and extended flag.
// - history is a saturating counter, new entries start strong taken.
// - allocate on execute exit when taken, not buffered, prediction enabled.
// - existing entry's counter updates on every execution of its branch while prediction is enabled.
// - reset leaves prediction enabled and all valid bits clear.
// - reset, cache invalidate, identifier write or invalidate bit clear all.
// - four-entry circular stack, calls in execute push the issue address.
// - return prediction is fixed by opcode class.
// - taken return in decode pops top and redirects fetch at once.
// - not-taken return pops only in execute when its condition is true.
// - saturating valid count; empty taken return still works, with penalty.
// - after reset the return stack is enabled and empty.
// - clearing stack enable disables it and discards all entries.
// - popping a return address for fetch flushes the prefetch queue.
`define BPRS_ADDR_W       32
`define BPRS_BTB_IDX_W    4
`define BPRS_RS_DEPTH     4
`define BPRS_RS_PTR_W     2
`define BPRS_RS_CNT_W     3
`define BPRS_HIST_SNT     2'h0
`define BPRS_HIST_WNT     2'h1
`define BPRS_HIST_WT      2'h2
`define BPRS_HIST_ST      2'h3
`define BPRS_CR_PRED_EN   0
`define BPRS_CR_INVAL     1
`define BPRS_CR_RS_EN     2
`define BPRS_CR_W         3
`define BPRS_CR_RESET     3'h5
`define BPRS_REG_CTRL     4'h0
`define BPRS_REG_STATUS   4'h4
`define BPRS_REG_ADDRESS_SPACE_IDENTIFIER     4'h8
`endif

// [pkg/bprs_pkg.sv]
package bprs_pkg;
  // branch kinds seen at decode / execute
  typedef enum logic [3:0] {
    BPRS_K_NONE     = 4'h0,
    BPRS_K_COND_K8  = 4'h1,
    BPRS_K_COND_K21 = 4'h2,
    BPRS_K_JMP_K10  = 4'h3,
    BPRS_K_JMP_K21  = 4'h4,
    BPRS_K_CALL_K10 = 4'h5,
    BPRS_K_CALL_K21 = 4'h6,
    BPRS_K_ALT_COND = 4'h7,
    BPRS_K_ALT_CMP  = 4'h8,
    BPRS_K_ICALL    = 4'h9,
    BPRS_K_MCALL    = 4'hA,
    BPRS_K_TCALL    = 4'hB
  } bprs_kind_t;
  // return forms
  typedef enum logic [2:0] {
    BPRS_R_NONE    = 3'h0,
    BPRS_R_MOV_LR  = 3'h1,
    BPRS_R_RET     = 3'h2,
    BPRS_R_POPM_PC = 3'h3,
    BPRS_R_LDM_PC  = 3'h4
  } bprs_ret_t;
  // bus slave states
  typedef enum logic [2:0] {
    BPRS_S_IDLE = 3'b001,
    BPRS_S_ACK  = 3'b010,
    BPRS_S_HOLD = 3'b100
  } bprs_bus_st_t;
endpackage

// [hdl/bprs_btb.sv]
`timescale 1ns/100ps
`include "bprs_cfg.svh"
module bprs_btb
  import bprs_pkg::*;
#(
  parameter int IDX_W = `BPRS_BTB_IDX_W
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic                    inval,
  input  wire logic [`BPRS_ADDR_W-1:0] look_addr,
  output logic                         look_hit,
  output logic                         look_taken,
  output logic [`BPRS_ADDR_W-1:0]      look_target,
  output logic                         look_ext,
  input  wire logic                    upd_valid,
  input  wire logic                    upd_alloc,
  input  wire logic                    upd_taken,
  input  wire logic [`BPRS_ADDR_W-1:0] upd_addr,
  input  wire logic [`BPRS_ADDR_W-1:0] upd_target,
  input  wire logic                    upd_ext,
  output logic                         upd_hit
);
  localparam int TAG_W = `BPRS_ADDR_W - IDX_W - 2;
  localparam int N     = 1 << IDX_W;
  typedef struct packed {
    logic [N-1:0] valid;
  } bprs_btb_st_t;
  bprs_btb_st_t r, nxt;
  logic [TAG_W-1:0]        tag_r  [N];
  logic [`BPRS_ADDR_W-1:0] tgt_r  [N];
  logic [1:0]              hist_r [N];
  logic [N-1:0]            ext_r;
  logic [IDX_W-1:0] li, ui;
  logic [TAG_W-1:0] lt, ut;
  assign li = look_addr[IDX_W+1:2];
  assign lt = look_addr[`BPRS_ADDR_W-1:IDX_W+2];
  assign ui = upd_addr[IDX_W+1:2];
  assign ut = upd_addr[`BPRS_ADDR_W-1:IDX_W+2];
  assign look_hit    = r.valid[li] && tag_r[li] == lt;
  assign look_taken  = hist_r[li][1];
  assign look_target = tgt_r[li];
  assign look_ext    = ext_r[li];
  assign upd_hit     = r.valid[ui] && tag_r[ui] == ut;
  always_comb
  begin
    nxt = r;
    if (upd_valid && upd_alloc && !upd_hit)
      nxt.valid[ui] = 1'b1;
    if (inval)
      nxt.valid = '0;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= nxt;
  end
  genvar g;
  for (g = 0; g < N; g++)
  begin : g_ent
    always_ff @(posedge clk)
    begin
      if (ce && upd_valid && ui == IDX_W'(g) && !inval)
      begin
        if (!upd_hit && upd_alloc)
        begin
          tag_r[g]  <= ut;
          tgt_r[g]  <= upd_target;
          ext_r[g]  <= upd_ext;
          hist_r[g] <= `BPRS_HIST_ST;
        end
        else if (upd_hit)
        begin
          if (upd_taken && hist_r[g] != `BPRS_HIST_ST)
            hist_r[g] <= hist_r[g] + 2'h1;
          else if (!upd_taken && hist_r[g] != `BPRS_HIST_SNT)
            hist_r[g] <= hist_r[g] - 2'h1;
        end
      end
    end
  end
endmodule

// [hdl/bprs_rstack.sv]
`timescale 1ns/100ps
`include "bprs_cfg.svh"
module bprs_rstack
  import bprs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic                    enable,
  input  wire logic                    flush,
  input  wire logic                    push,
  input  wire logic [`BPRS_ADDR_W-1:0] push_addr,
  input  wire logic                    pop,
  output logic                         empty,
  output logic [`BPRS_ADDR_W-1:0]      top,
  output logic [`BPRS_RS_CNT_W-1:0]    count
);
  typedef struct packed {
    logic [`BPRS_RS_PTR_W-1:0] tos;
    logic [`BPRS_RS_CNT_W-1:0] cnt;
  } bprs_rs_st_t;
  bprs_rs_st_t r, nxt;
  logic [`BPRS_ADDR_W-1:0] mem_r [`BPRS_RS_DEPTH];
  logic [`BPRS_RS_PTR_W-1:0] wp;
  assign wp    = r.tos + `BPRS_RS_PTR_W'(1);
  assign empty = r.cnt == '0;
  assign top   = mem_r[r.tos];
  assign count = r.cnt;
  always_comb
  begin
    nxt = r;
    if (!enable || flush)
      nxt.cnt = '0;
    else if (push && !pop)
    begin
      nxt.tos = wp;
      if (r.cnt != `BPRS_RS_CNT_W'(`BPRS_RS_DEPTH))
        nxt.cnt = r.cnt + `BPRS_RS_CNT_W'(1);
    end
    else if (pop && !push && !empty)
    begin
      nxt.tos = r.tos - `BPRS_RS_PTR_W'(1);
      nxt.cnt = r.cnt - `BPRS_RS_CNT_W'(1);
    end
    else if (pop && push && !empty)
      nxt.tos = r.tos;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= nxt;
  end
  always_ff @(posedge clk)
  begin
    if (ce && enable && !flush && push)
    begin
      if (pop && !empty)
        mem_r[r.tos] <= push_addr;
      else
        mem_r[wp] <= push_addr;
    end
  end
endmodule

// [dv/bprs_checker.sv]
`timescale 1ns/100ps
module bprs_checker
  import bprs_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        fetch_valid,
  input wire logic        id_valid,
  input wire bprs_kind_t  id_kind,
  input wire bprs_ret_t   id_ret,
  input wire logic        id_ret_always,
  input wire logic        ex_valid,
  input wire bprs_kind_t  ex_kind,
  input wire logic        ex_taken,
  input wire logic        ex_pred_taken,
  input wire logic [31:0] ex_target,
  input wire logic [31:0] ex_fallthru,
  input wire logic        pred_valid_r,
  input wire logic        fold_r,
  input wire logic        redirect_r,
  input wire logic [31:0] redirect_addr_r,
  input wire logic        flush_r,
  input wire logic        ret_pred_taken_r,
  input wire logic        ret_stall_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  bus_recovery_a: assert property ($fell(avs_waitrequest) |=>
    avs_waitrequest [*2]) else $error("bus recovery too short");
  bus_ack_cause_a: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write)) else $error("ack without request");
  lookup_cause_a: assert property (pred_valid_r |->
    $past(fetch_valid && ce)) else $error("prediction without lookup");
  mispredict_redir_a: assert property ((ce && ex_valid && ex_kind inside
    {BPRS_K_COND_K8, BPRS_K_COND_K21} && ex_taken != ex_pred_taken) |=>
    redirect_r && flush_r && redirect_addr_r ==
    $past(ex_taken ? ex_target : ex_fallthru)) else $error("bad recovery");
  ret_not_taken_a: assert property ((ce && id_valid &&
    id_ret == BPRS_R_RET && !id_ret_always) |=> !ret_pred_taken_r)
    else $error("conditional return predicted taken");
  ret_taken_a: assert property ((ce && id_valid && id_ret inside
    {BPRS_R_MOV_LR, BPRS_R_POPM_PC, BPRS_R_LDM_PC}) |=> ret_pred_taken_r)
    else $error("return not predicted taken");
  ret_flush_a: assert property (ret_pred_taken_r && !ret_stall_r |->
    flush_r) else $error("return pop without flush");
  stall_cause_a: assert property (ret_stall_r |->
    $past(id_valid && id_ret != BPRS_R_NONE)) else $error("stray stall");
  call_fold_a: assert property ((ce && id_valid && id_kind inside
    {BPRS_K_CALL_K10, BPRS_K_CALL_K21}) |=> !fold_r)
    else $error("call folded");
  redirect_c: cover property (redirect_r);
  stall_c: cover property (ret_stall_r);
  hit_c: cover property (pred_valid_r);
endmodule
bind bprs_top bprs_checker u_bprs_checker (.clk(clk), .nrst(nrst),
  .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .fetch_valid(fetch_valid),
  .id_valid(id_valid), .id_kind(id_kind), .id_ret(id_ret),
  .id_ret_always(id_ret_always), .ex_valid(ex_valid), .ex_kind(ex_kind),
  .ex_taken(ex_taken), .ex_pred_taken(ex_pred_taken),
  .ex_target(ex_target), .ex_fallthru(ex_fallthru),
  .pred_valid_r(pred_valid_r), .fold_r(fold_r), .redirect_r(redirect_r),
  .redirect_addr_r(redirect_addr_r), .flush_r(flush_r),
  .ret_pred_taken_r(ret_pred_taken_r), .ret_stall_r(ret_stall_r));

// [dv/bprs_fetch_model.sv]
`timescale 1ns/100ps
module bprs_fetch_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [31:0] go_addr,
  input  wire logic        redirect_r,
  input  wire logic [31:0] redirect_addr_r,
  output logic             fetch_valid,
  output logic [31:0]      fetch_addr
);
  typedef struct packed {logic v; logic [31:0] a;} bprs_fm_st_t;
  bprs_fm_st_t st_r;
  bprs_fm_st_t st_nxt;
  always_comb
  begin
    st_nxt = '{1'b0, ~st_r.a};
    if (go)
      st_nxt = '{1'b1, go_addr};
    else if (redirect_r)
      st_nxt = '{1'b1, redirect_addr_r};
  end
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  assign fetch_valid = st_r.v;
  assign fetch_addr  = st_r.a;
endmodule

// [dv/bprs_top_bench.sv]
`timescale 1ns/100ps
module bprs_top_bench
  import bprs_pkg::*;
;
  logic       clk, nrst, ce, avs_read, avs_write, avs_waitrequest, go;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, fetch_addr, ex_pc, ex_target;
  logic [31:0] ex_fallthru, is_pc, pred_target_r, redirect_addr_r, rd, go_addr;
  logic       icache_inval, rs_flush_op, fetch_valid, id_valid, id_foldable;
  logic       id_ret_always, ex_valid, ex_taken, ex_pred_taken, ex_ext;
  logic       ex_ret_cond_true, pred_valid_r, pred_taken_r, fold_r;
  logic       redirect_r, flush_r, ret_pred_taken_r, ret_stall_r;
  bprs_kind_t id_kind, ex_kind;
  bprs_ret_t  id_ret, ex_ret;
  int         failures, checks;
  bprs_top u_bprs_top (.clk(clk), .nrst(nrst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .icache_inval(icache_inval),
    .rs_flush_op(rs_flush_op), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .id_valid(id_valid), .id_kind(id_kind),
    .id_foldable(id_foldable), .id_ret(id_ret),
    .id_ret_always(id_ret_always), .ex_valid(ex_valid), .ex_kind(ex_kind),
    .ex_taken(ex_taken), .ex_pred_taken(ex_pred_taken),
    .ex_ret_cond_true(ex_ret_cond_true), .ex_ret(ex_ret), .ex_pc(ex_pc),
    .ex_target(ex_target), .ex_fallthru(ex_fallthru), .ex_ext(ex_ext),
    .is_pc(is_pc), .pred_valid_r(pred_valid_r), .pred_taken_r(pred_taken_r),
    .pred_target_r(pred_target_r), .fold_r(fold_r), .redirect_r(redirect_r),
    .redirect_addr_r(redirect_addr_r), .flush_r(flush_r),
    .ret_pred_taken_r(ret_pred_taken_r), .ret_stall_r(ret_stall_r));
  bprs_fetch_model u_bprs_fetch_model (.clk(clk), .nrst(nrst), .go(go),
    .go_addr(go_addr), .redirect_r(redirect_r),
    .redirect_addr_r(redirect_addr_r), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task print_verdict;
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    if (n >= 50)
    begin
      failures++;
      print_verdict;
    end
  endtask
  task tick;
    @(posedge clk);
    {id_valid, ex_valid, go, icache_inval, rs_flush_op} <= 5'h0;
    ex_ret <= BPRS_R_NONE;
    #1;
  endtask
  task ex(bprs_kind_t k, logic t, logic p, logic [31:0] pc, logic [31:0] tg);
    @(posedge clk);
    {ex_valid, ex_kind, ex_taken, ex_pred_taken} <= {1'b1, k, t, p};
    {ex_pc, ex_target, ex_fallthru} <= {pc, tg, pc + 32'h4};
    tick;
  endtask
  task look(logic [31:0] a, logic h, logic t, logic [31:0] tg);
    @(posedge clk);
    {go, go_addr} <= {1'b1, a};
    @(posedge clk);
    go <= 1'b0;
    tick;
    chk(pred_valid_r, h);
    if (h)
    begin
      chk(pred_taken_r, t);
      chk(pred_target_r, tg);
    end
  endtask
  task call(bprs_kind_t k, logic [31:0] a);
    @(posedge clk);
    {id_valid, id_kind, is_pc} <= {1'b1, k, a};
    {ex_valid, ex_kind, ex_taken, ex_pred_taken} <= {1'b1, k, 2'h3};
    {ex_pc, ex_target, ex_fallthru} <= {a - 32'h4, 32'h9000, a};
    tick;
  endtask
  task ret(bprs_ret_t r, logic al);
    @(posedge clk);
    {id_valid, id_kind, id_ret, id_ret_always} <= {1'b1, BPRS_K_NONE, r, al};
    tick;
  endtask
  task t_regs;
    bus(0, 4'h0, 32'h0);
    chk(rd, 32'h5);
    bus(0, 4'h4, 32'h0);
    chk(rd, 32'h8);
    bus(0, 4'hC, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_btb;
    bprs_kind_t k[4];
    k = '{BPRS_K_COND_K8, BPRS_K_COND_K21, BPRS_K_JMP_K10, BPRS_K_JMP_K21};
    for (int i = 0; i < 4; i++)
    begin
      ex(k[i], 1'b1, 1'b1, 32'h1000 + 32'(i * 16), 32'h2000 + 32'(i));
      look(32'h1000 + 32'(i * 16), 1'b1, 1'b1, 32'h2000 + 32'(i));
    end
    ex(BPRS_K_COND_K8, 1'b0, 1'b0, 32'h1000, 32'h2000);
    look(32'h1000, 1'b1, 1'b1, 32'h2000);
    ex(BPRS_K_COND_K8, 1'b0, 1'b0, 32'h1000, 32'h2000);
    look(32'h1002, 1'b1, 1'b0, 32'h2000);
    ex(BPRS_K_COND_K8, 1'b1, 1'b0, 32'h1000, 32'h2000);
    chk({redirect_r, flush_r, redirect_addr_r}, {2'h3, 32'h2000});
    look(32'h1000, 1'b1, 1'b1, 32'h2000);
    look(32'h5000, 1'b0, 1'b0, 32'h0);
    ex(BPRS_K_COND_K21, 1'b0, 1'b1, 32'h6100, 32'h6800);
    chk({redirect_r, flush_r, redirect_addr_r}, {2'h3, 32'h6104});
  endtask
  task t_inval;
    for (int j = 0; j < 3; j++)
    begin
      ex(BPRS_K_COND_K8, 1'b1, 1'b1, 32'h3000, 32'h3800);
      look(32'h3000, 1'b1, 1'b1, 32'h3800);
      if (j == 0)
        bus(1, 4'h0, 32'h7);
      else if (j == 1)
        bus(1, 4'h8, 32'h1);
      else
      begin
        @(posedge clk);
        icache_inval <= 1'b1;
        tick;
      end
      look(32'h3000, 1'b0, 1'b0, 32'h0);
    end
    bus(1, 4'h0, 32'h4);
    bus(0, 4'h0, 32'h0);
    chk(rd, 32'h4);
    ex(BPRS_K_COND_K8, 1'b1, 1'b1, 32'h4000, 32'h4800);
    look(32'h4000, 1'b0, 1'b0, 32'h0);
    bus(1, 4'h0, 32'h7);
  endtask
  task t_rs;
    bprs_kind_t c[5];
    bprs_ret_t r[4];
    c = '{BPRS_K_CALL_K10, BPRS_K_CALL_K21, BPRS_K_ICALL, BPRS_K_MCALL,
          BPRS_K_TCALL};
    r = '{BPRS_R_MOV_LR, BPRS_R_RET, BPRS_R_POPM_PC, BPRS_R_LDM_PC};
    for (int i = 0; i < 5; i++)
      call(c[i], 32'h7000 + 32'(i * 16));
    bus(0, 4'h4, 32'h0);
    chk(rd, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      ret(r[i], 1'b1);
      chk({ret_pred_taken_r, flush_r, redirect_addr_r},
          {2'h3, 32'h7040 - 32'(i * 16)});
    end
    ret(BPRS_R_RET, 1'b1);
    chk(ret_stall_r, 1'b1);
    call(BPRS_K_CALL_K10, 32'h7100);
    ret(BPRS_R_RET, 1'b0);
    chk(ret_pred_taken_r, 1'b0);
    @(posedge clk);
    {ex_valid, ex_ret, ex_ret_cond_true} <= {1'b1, BPRS_R_RET, 1'b1};
    ex_kind <= BPRS_K_NONE;
    tick;
    bus(0, 4'h4, 32'h0);
    chk(rd, 32'h8);
    call(BPRS_K_ICALL, 32'h7200);
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h4, 32'h0);
    chk(rd, 32'h8);
    bus(1, 4'h0, 32'h5);
    call(BPRS_K_MCALL, 32'h7300);
    @(posedge clk);
    rs_flush_op <= 1'b1;
    tick;
    bus(0, 4'h4, 32'h0);
    chk(rd, 32'h8);
  endtask
  initial
  begin
    {nrst, ce, avs_read, avs_write, go, icache_inval, rs_flush_op} = 7'h20;
    {avs_address, avs_writedata, go_addr, is_pc} = '0;
    {id_valid, id_foldable, id_ret_always, ex_valid, ex_taken} = 5'h0;
    {ex_pred_taken, ex_ret_cond_true, ex_ext} = 3'h0;
    {ex_pc, ex_target, ex_fallthru} = '0;
    {id_kind, ex_kind, id_ret, ex_ret} = '0;
    failures = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_btb;
    t_inval;
    t_rs;
    print_verdict;
  end
endmodule
